// [bpq_pkg.sv]
// Package with the query table layout, contents and bus constants.
// ********************************************************************
// ********************************************************************
package bpq_pkg;

	// ****************************************************************
	// Bus layout.
	// ****************************************************************
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************************************
	// Location indexes; the byte address is four times the index.
	// ****************************************************************
	localparam logic [IDX_W-1:0] IDX_BURST_FIELD_COUNT = 10'h128;
	localparam logic [IDX_W-1:0] IDX_BURST_CONFIG_ONE = 10'h129;
	localparam logic [IDX_W-1:0] IDX_BURST_CONFIG_TWO = 10'h12A;
	localparam logic [IDX_W-1:0] IDX_BURST_CONFIG_THREE = 10'h12B;
	localparam logic [IDX_W-1:0] IDX_BURST_CONFIG_FOUR = 10'h12C;
	localparam logic [IDX_W-1:0] IDX_PARTITION_REGION_COUNT = 10'h12D;
	localparam logic [IDX_W-1:0] IDX_REGION_INFO_SIZE_LO = 10'h12E;
	localparam logic [IDX_W-1:0] IDX_REGION_INFO_SIZE_HI = 10'h12F;
	localparam logic [IDX_W-1:0] IDX_IDENTICAL_PARTITION_LO = 10'h130;
	localparam logic [IDX_W-1:0] IDX_IDENTICAL_PARTITION_HI = 10'h131;
	localparam logic [IDX_W-1:0] IDX_IN_PARTITION_OP_LIMITS = 10'h132;
	localparam logic [IDX_W-1:0] IDX_OPS_DURING_PROGRAM = 10'h133;
	localparam logic [IDX_W-1:0] IDX_OPS_DURING_ERASE = 10'h134;
	localparam logic [IDX_W-1:0] IDX_ERASE_REGION_TYPE_COUNT = 10'h135;
	localparam logic [IDX_W-1:0] IDX_ERASE_TYPE1_BASE = 10'h136;
	localparam logic [IDX_W-1:0] IDX_ERASE_TYPE1_LAST = 10'h139;

	// ****************************************************************
	// Field layout and contents.
	// ****************************************************************
	localparam int CFG_LEN_W = 3;
	localparam int CFG_RSVD_W = 5;
	localparam int NIB_W = 4;
	localparam logic [7:0] VAL_BURST_FIELD_COUNT = 8'h04;
	localparam logic [CFG_LEN_W-1:0] CFG_LEN_FOUR = 3'h1;
	localparam logic [CFG_LEN_W-1:0] CFG_LEN_EIGHT = 3'h2;
	localparam logic [CFG_LEN_W-1:0] CFG_LEN_SIXTEEN = 3'h3;
	localparam logic [CFG_LEN_W-1:0] CFG_LEN_CONTINUOUS = 3'h7;
	localparam logic [7:0] VAL_PARTITION_REGION_COUNT = 8'h01;
	localparam logic [15:0] VAL_REGION_INFO_SIZE = 16'h0010;
	localparam logic [15:0] VAL_IDENTICAL_PARTITION = 16'h0001;
	localparam logic [NIB_W-1:0] VAL_LIMIT_PROG = 4'h1;
	localparam logic [NIB_W-1:0] VAL_LIMIT_ERASE = 4'h1;
	localparam logic [NIB_W-1:0] VAL_DURING_PROG_PROG = 4'h0;
	localparam logic [NIB_W-1:0] VAL_DURING_PROG_ERASE = 4'h0;
	localparam logic [NIB_W-1:0] VAL_DURING_ERASE_PROG = 4'h0;
	localparam logic [NIB_W-1:0] VAL_DURING_ERASE_ERASE = 4'h0;
	localparam logic [7:0] VAL_ERASE_REGION_TYPE_COUNT = 8'h01;
	localparam logic [15:0] VAL_TYPE1_BLOCKS_M1 = 16'h00FF;
	localparam logic [15:0] VAL_TYPE1_SIZE_256 = 16'h0200;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef struct packed {
		logic hit;
		logic [7:0] value;
	} bpq_entry_s;

	typedef enum logic [0:0] {
		BPQ_RD_IDLE = 1'b0,
		BPQ_RD_RESP = 1'b1
	} bpq_rd_state_e;

endpackage

// [bpq_table.sv]
// AXI4-Lite read-only slave that serves the burst and partition query table.
//
// The AXI4-Lite slave port was decided locally.
module bpq_table
	import bpq_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	// ****************************************************************
	// Table contents.
	// ****************************************************************
	function automatic logic [7:0] cfg_byte(input logic [CFG_LEN_W-1:0] n);
		cfg_byte = {{CFG_RSVD_W{1'b0}}, n};
	endfunction

	function automatic bpq_entry_s lookup(input logic [IDX_W-1:0] idx);
		lookup.hit = 1'b1;
		unique case (idx)
			IDX_BURST_FIELD_COUNT: lookup.value = VAL_BURST_FIELD_COUNT;
			IDX_BURST_CONFIG_ONE: lookup.value = cfg_byte(CFG_LEN_FOUR);
			IDX_BURST_CONFIG_TWO: lookup.value = cfg_byte(CFG_LEN_EIGHT);
			IDX_BURST_CONFIG_THREE: lookup.value = cfg_byte(CFG_LEN_SIXTEEN);
			IDX_BURST_CONFIG_FOUR: lookup.value = cfg_byte(CFG_LEN_CONTINUOUS);
			IDX_PARTITION_REGION_COUNT: lookup.value = VAL_PARTITION_REGION_COUNT;
			IDX_REGION_INFO_SIZE_LO: lookup.value = VAL_REGION_INFO_SIZE[7:0];
			IDX_REGION_INFO_SIZE_HI: lookup.value = VAL_REGION_INFO_SIZE[15:8];
			IDX_IDENTICAL_PARTITION_LO: lookup.value = VAL_IDENTICAL_PARTITION[7:0];
			IDX_IDENTICAL_PARTITION_HI: lookup.value = VAL_IDENTICAL_PARTITION[15:8];
			IDX_IN_PARTITION_OP_LIMITS: lookup.value = {VAL_LIMIT_ERASE, VAL_LIMIT_PROG};
			IDX_OPS_DURING_PROGRAM: lookup.value = {VAL_DURING_PROG_ERASE, VAL_DURING_PROG_PROG};
			IDX_OPS_DURING_ERASE: lookup.value = {VAL_DURING_ERASE_ERASE, VAL_DURING_ERASE_PROG};
			IDX_ERASE_REGION_TYPE_COUNT: lookup.value = VAL_ERASE_REGION_TYPE_COUNT;
			IDX_ERASE_TYPE1_BASE: lookup.value = VAL_TYPE1_BLOCKS_M1[7:0];
			IDX_ERASE_TYPE1_BASE + 10'h001: lookup.value = VAL_TYPE1_BLOCKS_M1[15:8];
			IDX_ERASE_TYPE1_BASE + 10'h002: lookup.value = VAL_TYPE1_SIZE_256[7:0];
			IDX_ERASE_TYPE1_LAST: lookup.value = VAL_TYPE1_SIZE_256[15:8];
			default: begin
				lookup.hit = 1'b0;
				lookup.value = 8'h00;
			end
		endcase
	endfunction

	// ****************************************************************
	// Read channel.
	// ****************************************************************
	bpq_rd_state_e rd_state_reg;
	bpq_rd_state_e rd_state_next;
	logic arready_reg;
	logic arready_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0] rresp_reg;
	logic [1:0] rresp_next;
	logic [IDX_W-1:0] rd_idx_reg;
	logic [IDX_W-1:0] rd_idx_next;
	bpq_entry_s rd_entry;

	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		rd_idx_next = rd_idx_reg;
		rd_entry = lookup(S_AXI_ARADDR[IDX_LSB +: IDX_W]);
		unique case (rd_state_reg)
			BPQ_RD_IDLE: begin
				if (S_AXI_ARVALID && arready_reg) begin
					rd_state_next = BPQ_RD_RESP;
					rd_idx_next = S_AXI_ARADDR[IDX_LSB +: IDX_W];
					rdata_next = {24'h000000, rd_entry.value};
					rresp_next = rd_entry.hit ? RESP_OKAY : RESP_DECERR;
				end
			end
			BPQ_RD_RESP: begin
				if (S_AXI_RREADY) begin
					rd_state_next = BPQ_RD_IDLE;
				end
			end
		endcase
		arready_next = (rd_state_next == BPQ_RD_IDLE);
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rd_state_reg <= BPQ_RD_IDLE;
			arready_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
			rd_idx_reg <= 10'h000;
		end else begin
			rd_state_reg <= rd_state_next;
			arready_reg <= arready_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			rd_idx_reg <= rd_idx_next;
		end
	end

	// ****************************************************************
	// Write channel; data is discarded and only a response is given.
	// ****************************************************************
	logic aw_got_reg;
	logic aw_got_next;
	logic w_got_reg;
	logic w_got_next;
	logic awready_reg;
	logic awready_next;
	logic wready_reg;
	logic wready_next;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;
	logic [1:0] bresp_next;
	logic [IDX_W-1:0] wr_idx_reg;
	logic [IDX_W-1:0] wr_idx_next;
	bpq_entry_s wr_entry;

	always_comb begin
		wr_entry = lookup(wr_idx_reg);
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		wr_idx_next = wr_idx_reg;
		if (S_AXI_AWVALID && awready_reg) begin
			aw_got_next = 1'b1;
			wr_idx_next = S_AXI_AWADDR[IDX_LSB +: IDX_W];
		end
		if (S_AXI_WVALID && wready_reg) begin
			w_got_next = 1'b1;
		end
		if (bvalid_reg) begin
			if (S_AXI_BREADY) begin
				bvalid_next = 1'b0;
			end
		end else if (aw_got_reg && w_got_reg) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_entry.hit ? RESP_OKAY : RESP_DECERR;
		end
		awready_next = !aw_got_next && !bvalid_next;
		wready_next = !w_got_next && !bvalid_next;
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			wr_idx_reg <= 10'h000;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			wr_idx_reg <= wr_idx_next;
		end
	end

	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = (rd_state_reg == BPQ_RD_RESP);
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_rd_take(logic [IDX_W-1:0] idx);
		S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR[IDX_LSB +: IDX_W] == idx);
	endsequence

	sequence s_rd_answer(logic [31:0] val);
		S_AXI_RVALID && (S_AXI_RDATA == val) && (S_AXI_RRESP == RESP_OKAY);
	endsequence

	property p_count;
		s_rd_take(IDX_BURST_FIELD_COUNT) |=> s_rd_answer(32'h00000004);
	endproperty
	a_count: assert property (p_count) else $error("Burst field count is not 4.");

	property p_cfg_one;
		s_rd_take(IDX_BURST_CONFIG_ONE) |=> s_rd_answer(32'h00000001);
	endproperty
	a_cfg_one: assert property (p_cfg_one) else $error("First burst configuration is not 1.");

	property p_cfg_two;
		s_rd_take(IDX_BURST_CONFIG_TWO) |=> s_rd_answer(32'h00000002);
	endproperty
	a_cfg_two: assert property (p_cfg_two) else $error("Second burst configuration is not 2.");

	property p_cfg_three;
		s_rd_take(IDX_BURST_CONFIG_THREE) |=> s_rd_answer(32'h00000003);
	endproperty
	a_cfg_three: assert property (p_cfg_three) else $error("Third burst configuration is not 3.");

	property p_cfg_four;
		s_rd_take(IDX_BURST_CONFIG_FOUR) |=> s_rd_answer(32'h00000007);
	endproperty
	a_cfg_four: assert property (p_cfg_four) else $error("Fourth burst configuration is not 7.");

	property p_cfg_rsvd;
		S_AXI_RVALID && (rd_idx_reg >= IDX_BURST_CONFIG_ONE) && (rd_idx_reg <= IDX_BURST_CONFIG_FOUR)
			|-> (S_AXI_RDATA[7:CFG_LEN_W] == 5'h00);
	endproperty
	a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("Burst configuration reserved bits set.");

	property p_continuous;
		S_AXI_RVALID && (rd_idx_reg == IDX_BURST_CONFIG_FOUR) |-> (S_AXI_RDATA[2:0] == 3'h7);
	endproperty
	a_continuous: assert property (p_continuous) else $error("Continuous burst code is not 7.");

	property p_size_pair;
		S_AXI_RVALID && (rd_idx_reg == IDX_REGION_INFO_SIZE_HI) |-> (S_AXI_RDATA[7:0] == VAL_REGION_INFO_SIZE[15:8]);
	endproperty
	a_size_pair: assert property (p_size_pair) else $error("Region size high byte wrong.");

	property p_low_byte;
		S_AXI_RVALID |-> (S_AXI_RDATA[31:8] == 24'h000000);
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("Read data above bit 7 is not zero.");

	property p_wr_answer;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			|=> ##1 (S_AXI_BVALID && $stable(rdata_reg));
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("Write answer late or table changed.");

	property p_rd_hold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("Read answer dropped before taken.");

	// ****************************************************************
	// Region contents and handshake checks.
	// ****************************************************************
	property p_regions;
		s_rd_take(IDX_PARTITION_REGION_COUNT) |=> s_rd_answer({24'h000000, VAL_PARTITION_REGION_COUNT});
	endproperty
	a_regions: assert property (p_regions) else $error("Partition region count wrong.");

	property p_size_lo;
		s_rd_take(IDX_REGION_INFO_SIZE_LO) |=> s_rd_answer({24'h000000, VAL_REGION_INFO_SIZE[7:0]});
	endproperty
	a_size_lo: assert property (p_size_lo) else $error("Region size low byte wrong.");

	property p_part_lo;
		s_rd_take(IDX_IDENTICAL_PARTITION_LO) |=> s_rd_answer({24'h000000, VAL_IDENTICAL_PARTITION[7:0]});
	endproperty
	a_part_lo: assert property (p_part_lo) else $error("Partition count low byte wrong.");

	property p_part_hi;
		s_rd_take(IDX_IDENTICAL_PARTITION_HI) |=> s_rd_answer({24'h000000, VAL_IDENTICAL_PARTITION[15:8]});
	endproperty
	a_part_hi: assert property (p_part_hi) else $error("Partition count high byte wrong.");

	property p_limits;
		s_rd_take(IDX_IN_PARTITION_OP_LIMITS) |=> s_rd_answer({24'h000000, VAL_LIMIT_ERASE, VAL_LIMIT_PROG});
	endproperty
	a_limits: assert property (p_limits) else $error("Partition operation limits wrong.");

	property p_during_prog;
		s_rd_take(IDX_OPS_DURING_PROGRAM) |=> s_rd_answer({24'h000000, VAL_DURING_PROG_ERASE, VAL_DURING_PROG_PROG});
	endproperty
	a_during_prog: assert property (p_during_prog) else $error("Operations during program wrong.");

	property p_during_erase;
		s_rd_take(IDX_OPS_DURING_ERASE) |=> s_rd_answer({24'h000000, VAL_DURING_ERASE_ERASE, VAL_DURING_ERASE_PROG});
	endproperty
	a_during_erase: assert property (p_during_erase) else $error("Operations during erase wrong.");

	property p_erase_types;
		s_rd_take(IDX_ERASE_REGION_TYPE_COUNT) |=> s_rd_answer({24'h000000, VAL_ERASE_REGION_TYPE_COUNT});
	endproperty
	a_erase_types: assert property (p_erase_types) else $error("Erase region count wrong.");

	property p_type1_b0;
		s_rd_take(IDX_ERASE_TYPE1_BASE) |=> s_rd_answer({24'h000000, VAL_TYPE1_BLOCKS_M1[7:0]});
	endproperty
	a_type1_b0: assert property (p_type1_b0) else $error("Block count low byte wrong.");

	property p_type1_b1;
		s_rd_take(IDX_ERASE_TYPE1_BASE + 10'h001) |=> s_rd_answer({24'h000000, VAL_TYPE1_BLOCKS_M1[15:8]});
	endproperty
	a_type1_b1: assert property (p_type1_b1) else $error("Block count high byte wrong.");

	property p_type1_b2;
		s_rd_take(IDX_ERASE_TYPE1_BASE + 10'h002) |=> s_rd_answer({24'h000000, VAL_TYPE1_SIZE_256[7:0]});
	endproperty
	a_type1_b2: assert property (p_type1_b2) else $error("Block size low byte wrong.");

	property p_type1_b3;
		s_rd_take(IDX_ERASE_TYPE1_LAST) |=> s_rd_answer({24'h000000, VAL_TYPE1_SIZE_256[15:8]});
	endproperty
	a_type1_b3: assert property (p_type1_b3) else $error("Block size high byte wrong.");

	property p_unmapped_rd;
		s_rd_take(IDX_ERASE_TYPE1_LAST + 10'h001) |=> S_AXI_RVALID && (S_AXI_RRESP == RESP_DECERR);
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("Unmapped read not refused.");

	property p_unmapped_zero;
		S_AXI_RVALID && (S_AXI_RRESP == RESP_DECERR) |-> (S_AXI_RDATA == 32'h00000000);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read data not zero.");

	property p_rd_latency;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("Read answer not one cycle after request.");

	property p_ar_refused;
		S_AXI_RVALID |-> !S_AXI_ARREADY;
	endproperty
	a_ar_refused: assert property (p_ar_refused) else $error("Read request accepted during answer.");

	property p_ar_back;
		S_AXI_RVALID && S_AXI_RREADY |=> S_AXI_ARREADY && !S_AXI_RVALID;
	endproperty
	a_ar_back: assert property (p_ar_back) else $error("Read channel not idle after answer.");

	property p_w_refused;
		S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY;
	endproperty
	a_w_refused: assert property (p_w_refused) else $error("Second write data accepted.");

	property p_aw_refused;
		S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY;
	endproperty
	a_aw_refused: assert property (p_aw_refused) else $error("Second write address accepted.");

	property p_bw_refused;
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_bw_refused: assert property (p_bw_refused) else $error("Write accepted during response.");

	property p_b_hold;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("Write response dropped before taken.");

	property p_b_taken;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY;
	endproperty
	a_b_taken: assert property (p_b_taken) else $error("Write channel not idle after response.");

endmodule

// [bpq_host_model.sv]
// Host controller model that reads and writes the query table over AXI4-Lite.
module bpq_host_model
	import bpq_pkg::*;
(
	input wire logic REF_CLK,
	output logic [ADDR_W-1:0] S_AXI_AWADDR,
	output logic [2:0] S_AXI_AWPROT,
	output logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	output logic [31:0] S_AXI_WDATA,
	output logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	output logic S_AXI_BREADY,
	output logic [ADDR_W-1:0] S_AXI_ARADDR,
	output logic [2:0] S_AXI_ARPROT,
	output logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	output logic S_AXI_RREADY
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0] burst_sel_reg;

	// ************************************************************
	// Idle levels; both response readies stay high throughout.
	// ************************************************************
	initial begin
		S_AXI_AWADDR = '0;
		S_AXI_AWPROT = 3'h0;
		S_AXI_AWVALID = 1'b0;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'h0;
		S_AXI_WVALID = 1'b0;
		S_AXI_BREADY = 1'b1;
		S_AXI_ARADDR = '0;
		S_AXI_ARPROT = 3'h0;
		S_AXI_ARVALID = 1'b0;
		S_AXI_RREADY = 1'b1;
		burst_sel_reg = 3'h0;
	end

	// ************************************************************
	// Bus cycles.
	// ************************************************************
	task automatic do_read(input logic [ADDR_W-1:0] addr, output logic [31:0] data, output logic [1:0] resp);
		S_AXI_ARADDR <= addr;
		S_AXI_ARVALID <= 1'b1;
		do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'b1);
		S_AXI_ARVALID <= 1'b0;
		while (S_AXI_RVALID !== 1'b1) @(posedge REF_CLK);
		data = S_AXI_RDATA;
		resp = S_AXI_RRESP;
	endtask

	task automatic do_write(input logic [ADDR_W-1:0] addr, input logic [31:0] data, output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		S_AXI_AWADDR <= addr;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= data;
		S_AXI_WSTRB <= 4'hF;
		S_AXI_WVALID <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge REF_CLK);
			if (!aw_done && S_AXI_AWREADY === 1'b1) begin
				aw_done = 1'b1;
				S_AXI_AWVALID <= 1'b0;
			end
			if (!w_done && S_AXI_WREADY === 1'b1) begin
				w_done = 1'b1;
				S_AXI_WVALID <= 1'b0;
			end
		end
		while (S_AXI_BVALID !== 1'b1) @(posedge REF_CLK);
		resp = S_AXI_BRESP;
	endtask

	// Copies the low 3 bits (length code) of a burst field into the host read setup.
	task automatic select_burst(input logic [7:0] cfg);
		burst_sel_reg = cfg[2:0];
	endtask
endmodule

// [tb_top.sv]
// Self-checking testbench for the burst and partition query table.
module tb_top
	import bpq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic REF_CLK;
	logic RESETN;
	logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	int mismatches;
	int n_compared;
	logic [7:0] got [0:17];

	bpq_table bpq_table_i (.*);
	bpq_host_model bpq_host_model_i (.*);

	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	// ************************************************************
	// Checking and closing.
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		n_compared++;
		if (seen !== expd) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, expd);
		end
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge REF_CLK);
		mismatches++;
		final_report();
	end

	// ************************************************************
	// Tests.
	// ************************************************************
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] y;
		logic [15:0] z;
		RESETN = 1'b0;
		mismatches = 0;
		n_compared = 0;
		repeat (20) @(posedge REF_CLK);
		RESETN <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			bpq_host_model_i.do_read({IDX_BURST_FIELD_COUNT + 10'(i), 2'b00}, d, r);
			check(32'(r), 32'(RESP_OKAY));
			check({d[31:8], 8'h00}, 32'h0);
			got[i] = d[7:0];
		end
		check(32'(got[0]), 32'h04);
		check(32'(got[1]), 32'h01);
		check(32'(got[2]), 32'h02);
		check(32'(got[3]), 32'h03);
		check(32'(got[4]), 32'h07);
		for (int i = 1; i < 5; i++) begin
			check(32'(got[i][7:3]), 32'h0);
			if (i < 4) check(32'(1) << (got[i][2:0] + 3'h1), 32'(1) << (i + 1));
		end
		bpq_host_model_i.select_burst(got[2]);
		check(32'(bpq_host_model_i.burst_sel_reg), 32'(CFG_LEN_EIGHT));
		check(32'(got[5]), 32'(VAL_PARTITION_REGION_COUNT));
		check(32'({got[7], got[6]}), 32'(VAL_REGION_INFO_SIZE));
		check(32'({got[9], got[8]}), 32'(VAL_IDENTICAL_PARTITION));
		check(32'(got[10]), 32'({VAL_LIMIT_ERASE, VAL_LIMIT_PROG}));
		check(32'(got[11]), 32'({VAL_DURING_PROG_ERASE, VAL_DURING_PROG_PROG}));
		check(32'(got[12]), 32'({VAL_DURING_ERASE_ERASE, VAL_DURING_ERASE_PROG}));
		check(32'(got[13]), 32'(VAL_ERASE_REGION_TYPE_COUNT));
		y = {got[15], got[14]};
		z = {got[17], got[16]};
		check(32'(y), 32'(VAL_TYPE1_BLOCKS_M1));
		check(32'(z), 32'(VAL_TYPE1_SIZE_256));
		check((32'(y) + 32'h1) * 32'(z) * 32'h100, 32'h0200_0000);
		bpq_host_model_i.do_write({IDX_BURST_FIELD_COUNT, 2'b00}, 32'hFFFF_FFFF, r);
		check(32'(r), 32'(RESP_OKAY));
		bpq_host_model_i.do_read({IDX_BURST_FIELD_COUNT, 2'b00}, d, r);
		check(d, 32'h0000_0004);
		bpq_host_model_i.do_write({IDX_ERASE_TYPE1_LAST + 10'h1, 2'b00}, 32'h0000_00A5, r);
		check(32'(r), 32'(RESP_DECERR));
		bpq_host_model_i.do_read({IDX_BURST_CONFIG_FOUR, 2'b11}, d, r);
		check(d, 32'h0000_0007);
		bpq_host_model_i.do_read({IDX_BURST_FIELD_COUNT - 10'h1, 2'b00}, d, r);
		check({d[31:2], r}, {30'h0, RESP_DECERR});
		bpq_host_model_i.do_read({IDX_ERASE_TYPE1_LAST + 10'h1, 2'b00}, d, r);
		check({d[31:2], r}, {30'h0, RESP_DECERR});
		final_report();
	end
endmodule
